// *** core/dmmd_decoder.sv ***
`timescale 1ns/100ps
`include "dmmd_params.svh"
// What this block does
// RULE1: ram fills upward from address zero
// RULE2: reset never clears or presets ram
// RULE3: F38h-FFFh decode as register region
// RULE4: unimplemented register addresses read zero
// RULE5: indirect addresses have no storage
// RULE6: fourth/fifth port regs only large package
// RULE7: nonvolatile address high only largest memory
// RULE8: 12-bit address, 16 banks of 256
// RULE9: unimplemented banks: writes ignored, reads zero
// RULE10: access offsets 00-5F bank0, 60-FF last
// RULE11: missing variant registers act unimplemented
module dmmd_decoder #(
  parameter int RAM_BANKS = 16,
  parameter bit HAS_PORT4 = 1'b1,
  parameter bit HAS_NV_HIGH = 1'b1
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // cpu addressing
  input wire logic [7:0] cpu_offset,
  input wire logic [3:0] bank_pointer,
  input wire logic use_access_bank,
  input wire logic use_full_addr,
  input wire logic [11:0] cpu_full_addr,
  // cpu data
  input wire logic cpu_rd,
  input wire logic cpu_wr,
  input wire logic [7:0] cpu_wdata,
  output logic [7:0] cpu_rdata,
  output logic cpu_rvalid,
  // register region side
  output logic sfr_wr,
  output logic sfr_rd,
  output logic [11:0] sfr_addr,
  output logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  // indirect access request
  output logic virt_access,
  output logic [11:0] virt_addr
);
  localparam int RAM_DEPTH = `DMMD_SFR_LO;
  if (RAM_BANKS < 1 || RAM_BANKS > `DMMD_BANKS) begin : g_bad_banks
    $error("RAM_BANKS must be 1..16");
  end

  // ----------------------------------------
  // address formation
  // ----------------------------------------
  wire logic [3:0] acc_bank = (cpu_offset < `DMMD_ACC_SPLIT) ? 4'h0 : `DMMD_LAST_BANK; // [RULE10]
  wire logic [3:0] eff_bank = use_access_bank ? acc_bank : bank_pointer;
  wire logic [11:0] eff_addr = use_full_addr ? cpu_full_addr : {eff_bank, cpu_offset}; // [RULE8]

  // ----------------------------------------
  // region decode
  // ----------------------------------------
  function automatic dmmd_pkg::dmmd_region_e classify(input logic [11:0] a);
    logic hole;
    logic absent;
    hole = (a == `DMMD_HOLE_A) || (a == `DMMD_HOLE_B) ||
      (a >= `DMMD_HOLE_C_LO && a <= `DMMD_HOLE_C_HI) ||
      (a >= `DMMD_HOLE_D_LO && a <= `DMMD_HOLE_D_HI) ||
      (a >= `DMMD_HOLE_E_LO && a <= `DMMD_HOLE_E_HI);
    absent = (!HAS_PORT4 && (a == `DMMD_P4_PINS || a == `DMMD_P4_DIR ||
      a == `DMMD_P4_LATCH || a == `DMMD_P5_LATCH)) || // [RULE6] [RULE11]
      (!HAS_NV_HIGH && a == `DMMD_NV_ADDR_HI); // [RULE7] [RULE11]
    if (a >= `DMMD_SFR_LO) begin // [RULE3]
      if ((a <= `DMMD_IND0_HI && a >= `DMMD_IND0_LO) || (a <= `DMMD_IND1_HI && a >= `DMMD_IND1_LO) ||
          (a <= `DMMD_IND2_HI && a >= `DMMD_IND2_LO)) begin
        classify = dmmd_pkg::DMMD_VIRT; // [RULE5]
      end else if (hole || absent) begin
        classify = dmmd_pkg::DMMD_UNIMP; // [RULE4]
      end else begin
        classify = dmmd_pkg::DMMD_SFR;
      end
    end else if (int'(a[11:8]) < RAM_BANKS) begin
      classify = dmmd_pkg::DMMD_RAM; // [RULE1]
    end else begin
      classify = dmmd_pkg::DMMD_UNIMP; // [RULE9]
    end
  endfunction : classify

  wire dmmd_pkg::dmmd_region_e region = classify(eff_addr);
  wire logic is_ram = (region == dmmd_pkg::DMMD_RAM);
  wire logic is_sfr = (region == dmmd_pkg::DMMD_SFR);
  wire logic is_virt = (region == dmmd_pkg::DMMD_VIRT);
  wire logic ram_wr = cpu_wr && is_ram; // [RULE9]

  // ----------------------------------------
  // ram storage
  // ----------------------------------------
  logic [7:0] ram_rdata;
  dmmd_ram #(
    .DEPTH(RAM_DEPTH),
    .AW(12)
  ) u_ram (
    .core_clk(core_clk),
    .wr_en(ram_wr), // [RULE2]
    .wr_addr(eff_addr),
    .wr_data(cpu_wdata),
    .rd_addr(eff_addr),
    .rd_data(ram_rdata)
  );

  // ----------------------------------------
  // pipeline and outputs
  // ----------------------------------------
  logic rd_q;
  dmmd_pkg::dmmd_region_e reg_q;
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rd_q <= 1'b0;
      reg_q <= dmmd_pkg::DMMD_UNIMP;
      sfr_wr <= 1'b0;
      sfr_rd <= 1'b0;
      sfr_addr <= 12'h000;
      sfr_wdata <= 8'h00;
      virt_access <= 1'b0;
      virt_addr <= 12'h000;
    end else begin
      rd_q <= cpu_rd;
      reg_q <= region;
      sfr_wr <= cpu_wr && is_sfr;
      sfr_rd <= cpu_rd && is_sfr;
      sfr_addr <= eff_addr;
      sfr_wdata <= cpu_wdata;
      virt_access <= (cpu_rd || cpu_wr) && is_virt; // [RULE5]
      virt_addr <= eff_addr;
    end
  end

  // read data one cycle after the ram/sfr sample
  wire logic [7:0] rdata_sel = (reg_q == dmmd_pkg::DMMD_RAM) ? ram_rdata :
    (reg_q == dmmd_pkg::DMMD_SFR) ? sfr_rdata : 8'h00; // [RULE4] [RULE9]
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cpu_rdata <= 8'h00;
      cpu_rvalid <= 1'b0;
    end else begin
      cpu_rdata <= rd_q ? rdata_sel : 8'h00;
      cpu_rvalid <= rd_q;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_unimp_zero;
    @(posedge core_clk) disable iff (!rst_n)
      (cpu_rd && region == dmmd_pkg::DMMD_UNIMP) |-> ##2 (cpu_rvalid && cpu_rdata == 8'h00);
  endproperty
  a_unimp_zero: assert property (p_unimp_zero) else $error("unimplemented read not zero"); // [RULE4]
  property p_top_is_sfr;
    @(posedge core_clk) disable iff (!rst_n)
      (cpu_wr && eff_addr >= `DMMD_SFR_LO && !is_virt && region != dmmd_pkg::DMMD_UNIMP) |=> sfr_wr;
  endproperty
  a_top_is_sfr: assert property (p_top_is_sfr) else $error("register region write not forwarded"); // [RULE3]
  property p_low_is_ram;
    @(posedge core_clk) disable iff (!rst_n)
      (eff_addr < `DMMD_SFR_LO && int'(eff_addr[11:8]) < RAM_BANKS) |-> ##0 (ram_wr == cpu_wr);
  endproperty
  a_low_is_ram: assert property (p_low_is_ram) else $error("ram write gating wrong"); // [RULE1]
  property p_virt_no_store;
    @(posedge core_clk) disable iff (!rst_n)
      (cpu_wr && is_virt) |=> (!sfr_wr && virt_access);
  endproperty
  a_virt_no_store: assert property (p_virt_no_store) else $error("indirect address stored"); // [RULE5]
  property p_port4_absent;
    @(posedge core_clk) disable iff (!rst_n)
      (!HAS_PORT4 && cpu_wr && eff_addr == `DMMD_P4_DIR) |=> !sfr_wr;
  endproperty
  a_port4_absent: assert property (p_port4_absent) else $error("absent port register written"); // [RULE6]
  property p_nvh_absent;
    @(posedge core_clk) disable iff (!rst_n)
      (!HAS_NV_HIGH && cpu_rd && eff_addr == `DMMD_NV_ADDR_HI) |-> ##2 (cpu_rdata == 8'h00);
  endproperty
  a_nvh_absent: assert property (p_nvh_absent) else $error("absent address high not zero"); // [RULE7] [RULE11]
  property p_bank_form;
    @(posedge core_clk) disable iff (!rst_n)
      (!use_full_addr && !use_access_bank) |-> (eff_addr[11:8] == bank_pointer);
  endproperty
  a_bank_form: assert property (p_bank_form) else $error("bank address wrong"); // [RULE8]
  property p_bank_ignore;
    @(posedge core_clk) disable iff (!rst_n)
      (cpu_wr && eff_addr < `DMMD_SFR_LO && int'(eff_addr[11:8]) >= RAM_BANKS) |-> !ram_wr ##1 !sfr_wr;
  endproperty
  a_bank_ignore: assert property (p_bank_ignore) else $error("write to absent bank"); // [RULE9]
  property p_access_map;
    @(posedge core_clk) disable iff (!rst_n)
      (use_access_bank && !use_full_addr) |->
      (eff_addr[11:8] == ((cpu_offset < `DMMD_ACC_SPLIT) ? 4'h0 : 4'hF));
  endproperty
  a_access_map: assert property (p_access_map) else $error("access bank map wrong"); // [RULE10]
  property p_ram_kept;
    @(posedge core_clk) (!rst_n && !cpu_wr) |-> !ram_wr;
  endproperty
  a_ram_kept: assert property (p_ram_kept) else $error("reset wrote ram"); // [RULE2]
  property p_sfr_rd_fwd;
    @(posedge core_clk) disable iff (!rst_n)
      (cpu_rd && is_sfr) |=> (sfr_rd && sfr_addr == $past(eff_addr));
  endproperty
  a_sfr_rd_fwd: assert property (p_sfr_rd_fwd) else $error("register region read not forwarded"); // [RULE3]
  property p_virt_rd_zero;
    @(posedge core_clk) disable iff (!rst_n)
      (cpu_rd && is_virt) |-> ##2 (cpu_rvalid && cpu_rdata == 8'h00);
  endproperty
  a_virt_rd_zero: assert property (p_virt_rd_zero) else $error("indirect read not zero"); // [RULE5]
  sequence s_rd_req;
    cpu_rd;
  endsequence
  sequence s_rd_answer;
    ##2 cpu_rvalid;
  endsequence
  property p_rd_latency;
    @(posedge core_clk) disable iff (!rst_n)
      s_rd_req |-> s_rd_answer;
  endproperty
  a_rd_latency: assert property (p_rd_latency) else $error("read answer late"); // [RULE8]
  property p_no_stray_valid;
    @(posedge core_clk) disable iff (!rst_n)
      (!cpu_rd) |-> ##2 !cpu_rvalid;
  endproperty
  a_no_stray_valid: assert property (p_no_stray_valid) else $error("read answer without request"); // [RULE8]
endmodule : dmmd_decoder

// *** core/dmmd_params.svh ***
`ifndef DMMD_PARAMS_SVH
`define DMMD_PARAMS_SVH
// ----------------------------------------
// address space
// ----------------------------------------
`define DMMD_ADDR_W 12
`define DMMD_DATA_W 8
`define DMMD_BANK_W 4
`define DMMD_BANKS 16
`define DMMD_BANK_SIZE 256
`define DMMD_RAM_BASE 12'h000
`define DMMD_SFR_LO 12'hF38
`define DMMD_SFR_HI 12'hFFF
`define DMMD_ACC_SPLIT 8'h60
`define DMMD_LAST_BANK 4'hF
// ----------------------------------------
// virtual indirect locations
// ----------------------------------------
`define DMMD_IND0_HI 12'hFEF
`define DMMD_IND0_LO 12'hFEB
`define DMMD_IND1_HI 12'hFE7
`define DMMD_IND1_LO 12'hFE3
`define DMMD_IND2_HI 12'hFDF
`define DMMD_IND2_LO 12'hFDB
// ----------------------------------------
// variant-specific registers
// ----------------------------------------
`define DMMD_P4_PINS 12'hF83
`define DMMD_P4_DIR 12'hF95
`define DMMD_P4_LATCH 12'hF8C
`define DMMD_P5_LATCH 12'hF8D
`define DMMD_NV_ADDR_HI 12'hFAA
// ----------------------------------------
// unimplemented holes in the register region
// ----------------------------------------
`define DMMD_HOLE_A 12'hFD4
`define DMMD_HOLE_B 12'hFB5
`define DMMD_HOLE_C_LO 12'hF97
`define DMMD_HOLE_C_HI 12'hF9A
`define DMMD_HOLE_D_LO 12'hF8E
`define DMMD_HOLE_D_HI 12'hF91
`define DMMD_HOLE_E_LO 12'hF85
`define DMMD_HOLE_E_HI 12'hF88
`endif

// *** core/dmmd_pkg.sv ***
package dmmd_pkg;
  typedef logic [11:0] dmmd_addr_t;
  typedef logic [7:0] dmmd_data_t;
  typedef enum logic [2:0] {
    DMMD_RAM,
    DMMD_SFR,
    DMMD_VIRT,
    DMMD_UNIMP
  } dmmd_region_e;
endpackage : dmmd_pkg

// *** core/dmmd_ram.sv ***
`timescale 1ns/100ps
// ----------------------------------------
// storage array, never cleared by reset
// ----------------------------------------
module dmmd_ram #(
  parameter int DEPTH = 3896,
  parameter int AW = 12
) (
  // clock
  input wire logic core_clk,
  // write
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [7:0] wr_data,
  // read
  input wire logic [AW-1:0] rd_addr,
  output logic [7:0] rd_data
);
  if (DEPTH < 1 || DEPTH > (1 << AW)) begin : g_bad_depth
    $error("dmmd_ram depth out of range");
  end
  logic [7:0] mem [DEPTH];
  // no reset branch: contents survive every reset [RULE2]
  always_ff @(posedge core_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end
  always_ff @(posedge core_clk) begin
    rd_data <= (int'(rd_addr) < DEPTH) ? mem[rd_addr] : 8'h00;
  end
endmodule : dmmd_ram

// *** sim/dmmd_sfr_model.sv ***
`timescale 1ns/100ps
// ----
// register region stand-in
// ----
module dmmd_sfr_model (
  // clock
  input wire logic core_clk,
  // register access
  input wire logic sfr_wr,
  input wire logic [11:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata
);
  logic [7:0] regs_q [200];
  logic in_region;
  int idx;
  assign in_region = sfr_addr >= 12'hF38;
  assign idx = int'(sfr_addr - 12'hF38);
  // outside the region: a changing pattern, never a held value
  assign sfr_rdata = in_region ? regs_q[idx] : ~sfr_addr[7:0];
  always @(posedge core_clk) begin
    if (sfr_wr && in_region) begin
      regs_q[idx] <= sfr_wdata;
    end
  end
endmodule : dmmd_sfr_model

// *** sim/dmmd_decoder_tb.sv ***
`timescale 1ns/100ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin failures++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module dmmd_decoder_tb;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] cpu_offset = 8'h00;
  logic [3:0] bank_pointer = 4'h0;
  logic use_access_bank = 1'b0;
  logic use_full_addr = 1'b1;
  logic [11:0] cpu_full_addr = 12'h000;
  logic cpu_rd = 1'b0;
  logic cpu_wr = 1'b0;
  logic [7:0] cpu_wdata = 8'h00;
  logic [7:0] rdata [2];
  logic rvalid [2];
  logic sfr_wr [2];
  logic sfr_rd [2];
  logic [11:0] sfr_addr [2];
  logic [7:0] sfr_wdata [2];
  logic [7:0] sfr_rdata [2];
  logic virt_access [2];
  logic [11:0] virt_addr [2];
  int failures = 0;
  int compares = 0;
  // row: address, write data, expected full variant, expected small variant
  logic [35:0] rows [16] = '{
    {12'h000, 8'h5A, 8'h5A, 8'h5A},
    {12'h5F0, 8'hA1, 8'hA1, 8'h00},
    {12'h3FF, 8'h3C, 8'h3C, 8'h3C},
    {12'hF37, 8'hC3, 8'hC3, 8'h00},
    {12'hF38, 8'h96, 8'h96, 8'h96},
    {12'hFFF, 8'h69, 8'h69, 8'h69},
    {12'hFD4, 8'h77, 8'h00, 8'h00},
    {12'hF97, 8'h78, 8'h00, 8'h00},
    {12'hFEF, 8'h11, 8'h00, 8'h00},
    {12'hFEB, 8'h12, 8'h00, 8'h00},
    {12'hFDF, 8'h13, 8'h00, 8'h00},
    {12'hF83, 8'h81, 8'h81, 8'h00},
    {12'hF95, 8'h82, 8'h82, 8'h00},
    {12'hF8C, 8'h83, 8'h83, 8'h00},
    {12'hF8D, 8'h84, 8'h84, 8'h00},
    {12'hFAA, 8'h85, 8'h85, 8'h00}
  };
  always #50 core_clk = ~core_clk;
  // full variant and a small one: 4 banks, no optional registers
  for (genvar g = 0; g < 2; g++) begin : gen_dut
    dmmd_decoder #(.RAM_BANKS(g ? 4 : 16), .HAS_PORT4(g == 0), .HAS_NV_HIGH(g == 0)) uut (
      .core_clk(core_clk), .rst_n(rst_n), .cpu_offset(cpu_offset), .bank_pointer(bank_pointer),
      .use_access_bank(use_access_bank), .use_full_addr(use_full_addr), .cpu_full_addr(cpu_full_addr),
      .cpu_rd(cpu_rd), .cpu_wr(cpu_wr), .cpu_wdata(cpu_wdata), .cpu_rdata(rdata[g]),
      .cpu_rvalid(rvalid[g]), .sfr_wr(sfr_wr[g]), .sfr_rd(sfr_rd[g]), .sfr_addr(sfr_addr[g]),
      .sfr_wdata(sfr_wdata[g]), .sfr_rdata(sfr_rdata[g]), .virt_access(virt_access[g]),
      .virt_addr(virt_addr[g])
    );
    dmmd_sfr_model sfr_model (
      .core_clk(core_clk), .sfr_wr(sfr_wr[g]), .sfr_addr(sfr_addr[g]),
      .sfr_wdata(sfr_wdata[g]), .sfr_rdata(sfr_rdata[g])
    );
  end
  task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d);
    cpu_full_addr = a;
    bank_pointer = a[11:8];
    cpu_offset = a[7:0];
    cpu_wdata = d;
    cpu_wr = w;
    cpu_rd = !w;
    @(posedge core_clk);
    #1;
  endtask : xfer
  task automatic idle();
    cpu_wr = 1'b0;
    cpu_rd = 1'b0;
  endtask : idle
  task automatic wait_chk(input logic [7:0] e0, input logic [7:0] e1);
    idle();
    @(posedge core_clk);
    #1;
    `CHK(rvalid[0], 1'b1)
    `CHK(rvalid[1], 1'b1)
    `CHK(rdata[0], e0)
    `CHK(rdata[1], e1)
  endtask : wait_chk
  task automatic rd_chk(input logic [11:0] a, input logic [7:0] e0, input logic [7:0] e1);
    xfer(1'b0, a, 8'h00);
    wait_chk(e0, e1);
  endtask : rd_chk
  task automatic stop_test();
    $display("failures=%0d compares=%0d", failures, compares);
    if (failures == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : stop_test
  initial begin
    #(100 * 5000);
    failures++;
    stop_test();
  end
  initial begin
    repeat (5) @(posedge core_clk);
    #1;
    rst_n = 1'b1;
    @(posedge core_clk);
    #1;
    foreach (rows[i]) begin
      xfer(1'b1, rows[i][35:24], rows[i][23:16]);
      rd_chk(rows[i][35:24], rows[i][15:8], rows[i][7:0]);
    end
    // back-to-back write then read of one ram byte
    xfer(1'b1, 12'h2A5, 8'hE7);
    xfer(1'b0, 12'h2A5, 8'h00);
    `CHK(sfr_rd[0], 1'b0)
    wait_chk(8'hE7, 8'hE7);
    // register region read is forwarded with its address
    xfer(1'b0, 12'hF38, 8'h00);
    `CHK(sfr_rd[0], 1'b1)
    `CHK(sfr_addr[0], 12'hF38)
    wait_chk(8'h96, 8'h96);
    // fast-access space, then bank pointer path
    use_full_addr = 1'b0;
    use_access_bank = 1'b1;
    xfer(1'b1, 12'h710, 8'h4D);
    xfer(1'b1, 12'h260, 8'h6B);
    use_access_bank = 1'b0;
    xfer(1'b1, 12'h344, 8'h19);
    use_full_addr = 1'b1;
    rd_chk(12'h010, 8'h4D, 8'h4D);
    rd_chk(12'hF60, 8'h6B, 8'h6B);
    rd_chk(12'h344, 8'h19, 8'h19);
    // indirect write raises the request, not storage
    xfer(1'b1, 12'hFEF, 8'h55);
    `CHK(virt_access[0], 1'b1)
    `CHK(virt_access[1], 1'b1)
    `CHK(virt_addr[0], 12'hFEF)
    `CHK(sfr_wr[0], 1'b0)
    `CHK(sfr_wdata[0], 8'h55)
    // ram survives a reset
    xfer(1'b1, 12'h123, 8'h9C);
    idle();
    rst_n = 1'b0;
    repeat (5) @(posedge core_clk);
    #1;
    `CHK(rvalid[0], 1'b0)
    rst_n = 1'b1;
    @(posedge core_clk);
    #1;
    rd_chk(12'h123, 8'h9C, 8'h9C);
    stop_test();
  end
endmodule : dmmd_decoder_tb
